// *** logic/pfh_defs.vh ***
// constants for the processor fault handling block
// assumes inclusion by each design file of the block that uses its names; definitions only
`ifndef PFH_DEFS_VH
`define PFH_DEFS_VH

// exception numbers this block routes to or compares the running class against
`define PFH_EXC_THREAD 4'h0
`define PFH_EXC_NMI 4'h2
`define PFH_EXC_HARD 4'h3
`define PFH_EXC_MEM 4'h4
`define PFH_EXC_BUS 4'h5
`define PFH_EXC_USAGE 4'h6

// configurable priority width
`define PFH_PRI_W 3

// hard_fault_cause bits
`define PFH_HF_W 2
`define PFH_HF_TABLE 1
`define PFH_HF_ESC 0

// memory_fault_cause bits
`define PFH_MF_W 4
`define PFH_MF_INSTR 0
`define PFH_MF_DATA 1
`define PFH_MF_POP 2
`define PFH_MF_PUSH 3

// bus_fault_cause bits
`define PFH_BF_W 5
`define PFH_BF_PREFETCH 0
`define PFH_BF_PRECISE 1
`define PFH_BF_DEFERRED 2
`define PFH_BF_POP 3
`define PFH_BF_PUSH 4

// usage_fault_cause bits
`define PFH_UF_W 6
`define PFH_UF_UNKNOWN 0
`define PFH_UF_STATE 1
`define PFH_UF_RETURN 2
`define PFH_UF_COPROC 3
`define PFH_UF_ALIGN 4
`define PFH_UF_ZERO_DIVISOR_FLAG 5

// handler return code: upper bits all ones, three legal low nibbles
`define PFH_RET_HIGH 28'hFFFFFFF
`define PFH_RET_HANDLER_MAIN 4'h1
`define PFH_RET_THREAD_MAIN 4'h9
`define PFH_RET_THREAD_PROC 4'hD

// reset values
`define PFH_ADDR_RST 32'h00000000
`define PFH_PRI_RST 3'h0

`endif

// *** logic/pfh_sticky.v ***
// per-bit sticky cause flags with write-one-to-clear
// assumes set and clear come from logic on the same clock
`timescale 1ns/100ps
module pfh_sticky #(
  parameter W = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] set_i,
  input wire [W-1:0] clr_i,
  output wire [W-1:0] flag_o
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg flag;
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          flag <= 1'b0;
        end else if (set_i[g]) begin
          flag <= 1'b1;
        end else if (clr_i[g]) begin
          flag <= 1'b0;
        end
      end
      assign flag_o[g] = flag;
    end
  endgenerate
endmodule // pfh_sticky

// *** logic/pfh_return_check.v ***
// handler return code validity check
// assumes the code is the value just loaded into the program counter
`timescale 1ns/100ps
`include "pfh_defs.vh"
module pfh_return_check (
  input wire [31:0] code_i,
  output wire valid_o
);
  wire high_ok;
  wire low_ok;
  assign high_ok = (code_i[31:4] == `PFH_RET_HIGH);
  assign low_ok = (code_i[3:0] == `PFH_RET_HANDLER_MAIN) ||
                  (code_i[3:0] == `PFH_RET_THREAD_MAIN) ||
                  (code_i[3:0] == `PFH_RET_THREAD_PROC);
  assign valid_o = high_ok && low_ok;
endmodule // pfh_return_check

// *** logic/pfh_fault_unit.v ***
// fault detection, routing, escalation and lockup for the processor core
// assumes all event inputs are one-cycle pulses from core logic on clk_i
`timescale 1ns/100ps
`include "pfh_defs.vh"
module pfh_fault_unit (
  input wire clk_i,
  input wire rst_i,
  input wire fetch_bus_err_i,
  input wire vector_bus_err_i,
  input wire data_bus_err_i,
  input wire deferred_bus_err_i,
  input wire push_bus_err_i,
  input wire pop_bus_err_i,
  input wire mpu_instr_viol_i,
  input wire no_exec_fetch_i,
  input wire mpu_data_viol_i,
  input wire mpu_push_viol_i,
  input wire mpu_pop_viol_i,
  input wire coproc_access_i,
  input wire unknown_opcode_i,
  input wire foreign_iset_i,
  input wire bad_resume_i,
  input wire branch_state_change_i,
  input wire misaligned_i,
  input wire zero_divide_i,
  input wire return_load_i,
  input wire [31:0] return_code_i,
  input wire [31:0] access_addr_i,
  input wire [3:0] cur_exc_i,
  input wire [`PFH_PRI_W-1:0] cur_pri_i,
  input wire [`PFH_PRI_W-1:0] mem_pri_i,
  input wire [`PFH_PRI_W-1:0] bus_pri_i,
  input wire [`PFH_PRI_W-1:0] usage_pri_i,
  input wire mem_en_i,
  input wire bus_en_i,
  input wire usage_en_i,
  input wire nmi_i,
  input wire [`PFH_HF_W-1:0] hard_clr_i,
  input wire [`PFH_MF_W-1:0] mem_clr_i,
  input wire [`PFH_BF_W-1:0] bus_clr_i,
  input wire [`PFH_UF_W-1:0] usage_clr_i,
  output reg fault_take_o,
  output reg [3:0] fault_exc_o,
  output reg lockup_o,
  output wire [`PFH_HF_W-1:0] hard_fault_cause_o,
  output wire [`PFH_MF_W-1:0] memory_fault_cause_o,
  output wire [`PFH_BF_W-1:0] bus_fault_cause_o,
  output wire [`PFH_UF_W-1:0] usage_fault_cause_o,
  output reg [31:0] memory_fault_location_o,
  output reg [31:0] bus_fault_location_o
);

  ////////////////////////////////////////////////////////////////////////////
  // cause detection

  wire ret_valid;
  wire bad_return;
  wire [`PFH_MF_W-1:0] mem_ev;
  wire [`PFH_BF_W-1:0] bus_ev;
  wire [`PFH_UF_W-1:0] usage_ev;
  wire mem_any;
  wire bus_any;
  wire usage_any;

  pfh_return_check u_ret (
    .code_i(return_code_i),
    .valid_o(ret_valid)
  );

  // a return code is judged only on the cycle it is loaded
  assign bad_return = return_load_i && !ret_valid;

  // a locked core runs nothing, so its fault inputs carry no meaning
  assign mem_ev[`PFH_MF_INSTR] = !lockup_o && (mpu_instr_viol_i || no_exec_fetch_i);
  assign mem_ev[`PFH_MF_DATA] = !lockup_o && mpu_data_viol_i;
  assign mem_ev[`PFH_MF_PUSH] = !lockup_o && mpu_push_viol_i;
  assign mem_ev[`PFH_MF_POP] = !lockup_o && mpu_pop_viol_i;

  assign bus_ev[`PFH_BF_PREFETCH] = !lockup_o && fetch_bus_err_i;
  assign bus_ev[`PFH_BF_PRECISE] = !lockup_o && data_bus_err_i;
  assign bus_ev[`PFH_BF_DEFERRED] = !lockup_o && deferred_bus_err_i;
  assign bus_ev[`PFH_BF_PUSH] = !lockup_o && push_bus_err_i;
  assign bus_ev[`PFH_BF_POP] = !lockup_o && pop_bus_err_i;

  assign usage_ev[`PFH_UF_COPROC] = !lockup_o && coproc_access_i;
  assign usage_ev[`PFH_UF_UNKNOWN] = !lockup_o && unknown_opcode_i;
  assign usage_ev[`PFH_UF_RETURN] = !lockup_o && bad_return;
  assign usage_ev[`PFH_UF_ALIGN] = !lockup_o && misaligned_i;
  assign usage_ev[`PFH_UF_ZERO_DIVISOR_FLAG] = !lockup_o && zero_divide_i;
  // three causes share one state flag; software cannot tell them apart
  assign usage_ev[`PFH_UF_STATE] = !lockup_o &&
    (foreign_iset_i || bad_resume_i || branch_state_change_i);

  assign mem_any = |mem_ev;
  assign bus_any = |bus_ev;
  assign usage_any = |usage_ev;

  ////////////////////////////////////////////////////////////////////////////
  // escalation decision

  wire in_handler;
  wire in_fixed;
  wire mem_esc;
  wire bus_esc;
  wire usage_esc;
  wire push_into_bus;
  wire bus_other;

  assign in_handler = (cur_exc_i != `PFH_EXC_THREAD);
  // NMI and hard fault run above every configurable level
  assign in_fixed = (cur_exc_i == `PFH_EXC_NMI) || (cur_exc_i == `PFH_EXC_HARD);

  // stacking for the bus handler itself is let through, stack left corrupt
  // any other bus cause in the same cycle is a fault of its own
  assign bus_other = bus_ev[`PFH_BF_PREFETCH] || bus_ev[`PFH_BF_PRECISE] ||
    bus_ev[`PFH_BF_DEFERRED] || bus_ev[`PFH_BF_POP];
  assign push_into_bus = bus_ev[`PFH_BF_PUSH] && (cur_exc_i == `PFH_EXC_BUS) &&
    !bus_other;

  // a larger priority value is less urgent, so an equal or larger value
  // cannot preempt the running handler and escalates instead
  // a disabled handler escalates even from thread level
  assign mem_esc = mem_any && (!mem_en_i || in_fixed ||
    cur_exc_i == `PFH_EXC_MEM ||
    (in_handler && mem_pri_i >= cur_pri_i));
  assign bus_esc = bus_any && !push_into_bus && (!bus_en_i || in_fixed ||
    cur_exc_i == `PFH_EXC_BUS ||
    (in_handler && bus_pri_i >= cur_pri_i));
  assign usage_esc = usage_any && (!usage_en_i || in_fixed ||
    cur_exc_i == `PFH_EXC_USAGE ||
    (in_handler && usage_pri_i >= cur_pri_i));

  wire vec_err;
  wire any_esc;
  wire hard_hit;
  wire mem_go;
  wire bus_go;
  wire usage_go;

  // a vector read error has no configurable handler to fall back on
  assign vec_err = !lockup_o && vector_bus_err_i;
  assign any_esc = mem_esc || bus_esc || usage_esc;
  assign hard_hit = vec_err || any_esc;
  assign mem_go = mem_any && !mem_esc;
  assign bus_go = bus_any && !bus_esc;
  assign usage_go = usage_any && !usage_esc;

  ////////////////////////////////////////////////////////////////////////////
  // target selection

  reg [3:0] next_exc;
  reg next_take;
  reg [`PFH_PRI_W-1:0] best_pri;

  // hard fault wins outright; among the rest the lower value wins and ties
  // fall to the lower exception number by checking in ascending order
  always @* begin
    next_exc = `PFH_EXC_THREAD;
    next_take = 1'b0;
    best_pri = `PFH_PRI_RST;
    if (hard_hit) begin
      next_exc = `PFH_EXC_HARD;
      next_take = 1'b1;
    end else begin
      if (mem_go) begin
        next_exc = `PFH_EXC_MEM;
        next_take = 1'b1;
        best_pri = mem_pri_i;
      end
      if (bus_go && (!next_take || bus_pri_i < best_pri)) begin
        next_exc = `PFH_EXC_BUS;
        next_take = 1'b1;
        best_pri = bus_pri_i;
      end
      if (usage_go && (!next_take || usage_pri_i < best_pri)) begin
        next_exc = `PFH_EXC_USAGE;
        next_take = 1'b1;
        best_pri = usage_pri_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lockup

  wire lock_enter;
  reg lock_from_nmi;

  assign lock_enter = hard_hit && in_fixed;

  // entry from the nmi handler is remembered, since a later nmi would
  // only re-enter the handler that locked
  // reset is then the only way out
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lockup_o <= 1'b0;
      lock_from_nmi <= 1'b0;
    end else if (lock_enter) begin
      lockup_o <= 1'b1;
      lock_from_nmi <= (cur_exc_i == `PFH_EXC_NMI);
    end else if (lockup_o && nmi_i && !lock_from_nmi) begin
      lockup_o <= 1'b0;
      lock_from_nmi <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dispatch to the core

  // a hard fault that locks the core is not dispatched
  // fault_exc_o reads as thread level whenever nothing is taken
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_take_o <= 1'b0;
      fault_exc_o <= `PFH_EXC_THREAD;
    end else begin
      fault_take_o <= next_take && !lock_enter;
      fault_exc_o <= lock_enter ? `PFH_EXC_THREAD : next_exc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cause flags

  wire [`PFH_HF_W-1:0] hard_ev;

  assign hard_ev[`PFH_HF_TABLE] = vec_err;
  assign hard_ev[`PFH_HF_ESC] = any_esc;

  // the escalation flag marks the route, the class flag keeps the origin
  // set wins over a clear in the same cycle so no event is lost
  pfh_sticky #(.W(`PFH_HF_W)) u_hard (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(hard_ev),
    .clr_i(hard_clr_i),
    .flag_o(hard_fault_cause_o)
  );

  pfh_sticky #(.W(`PFH_MF_W)) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(mem_ev),
    .clr_i(mem_clr_i),
    .flag_o(memory_fault_cause_o)
  );

  pfh_sticky #(.W(`PFH_BF_W)) u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(bus_ev),
    .clr_i(bus_clr_i),
    .flag_o(bus_fault_cause_o)
  );

  pfh_sticky #(.W(`PFH_UF_W)) u_usage (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(usage_ev),
    .clr_i(usage_clr_i),
    .flag_o(usage_fault_cause_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fault addresses

  // only precise data faults carry a known address; fetch, stack and deferred faults
  // leave the last captured value in place
  // a flag clear does not erase the address; only reset does
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      memory_fault_location_o <= `PFH_ADDR_RST;
      bus_fault_location_o <= `PFH_ADDR_RST;
    end else begin
      if (mem_ev[`PFH_MF_DATA]) begin
        memory_fault_location_o <= access_addr_i;
      end
      if (bus_ev[`PFH_BF_PRECISE]) begin
        bus_fault_location_o <= access_addr_i;
      end
    end
  end

endmodule // pfh_fault_unit

// *** verif/pfh_fault_unit_sva.sv ***
// checker for the fault unit: routing, escalation, capture, lockup
// assumes one clock domain with async active-high reset
`timescale 1ns/100ps
`include "pfh_defs.vh"
module pfh_chk (
  input wire clk_i,
  input wire rst_i,
  input wire vector_bus_err_i,
  input wire data_bus_err_i,
  input wire misaligned_i,
  input wire zero_divide_i,
  input wire usage_en_i,
  input wire nmi_i,
  input wire [3:0] cur_exc_i,
  input wire [31:0] access_addr_i,
  input wire [`PFH_UF_W-1:0] usage_clr_i,
  input wire fault_take_o,
  input wire [3:0] fault_exc_o,
  input wire lockup_o,
  input wire [`PFH_HF_W-1:0] hard_fault_cause_o,
  input wire [`PFH_BF_W-1:0] bus_fault_cause_o,
  input wire [`PFH_UF_W-1:0] usage_fault_cause_o,
  input wire [31:0] bus_fault_location_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // thread level and not locked: no priority escalation or lockup path can interfere
  wire live = !lockup_o && cur_exc_i == 4'h0;
  property p_vec;
    vector_bus_err_i && live |=> fault_take_o && fault_exc_o == 4'h3 && hard_fault_cause_o[1];
  endproperty
  a_vec: assert property (p_vec) else $error("vector error not routed");
  property p_prec;
    data_bus_err_i && live |=> bus_fault_cause_o[1] && bus_fault_location_o == $past(access_addr_i);
  endproperty
  a_prec: assert property (p_prec) else $error("precise error capture wrong");
  property p_dis;
    zero_divide_i && !usage_en_i && live |=> fault_exc_o == 4'h3 && hard_fault_cause_o[0];
  endproperty
  a_dis: assert property (p_dis) else $error("disabled handler not escalated");
  property p_same;
    misaligned_i && !lockup_o && cur_exc_i == 4'h6 |=> fault_take_o && fault_exc_o == 4'h3;
  endproperty
  a_same: assert property (p_same) else $error("same class not escalated");
  property p_lock;
    zero_divide_i && !lockup_o && cur_exc_i == 4'h3 |=> lockup_o && !fault_take_o;
  endproperty
  a_lock: assert property (p_lock) else $error("no lockup from hard handler");
  property p_quiet;
    lockup_o |=> !fault_take_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("dispatch while locked");
  property p_hold;
    lockup_o && !nmi_i |=> lockup_o;
  endproperty
  a_hold: assert property (p_hold) else $error("lockup left without nmi");
  property p_sticky;
    usage_fault_cause_o[5] && !usage_clr_i[5] |=> usage_fault_cause_o[5];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped uncleared");
  c_lock: cover property ($rose(lockup_o));
  c_bus: cover property (fault_take_o && fault_exc_o == 4'h5);
  c_esc: cover property ($rose(hard_fault_cause_o[0]));
endmodule // pfh_chk

bind pfh_fault_unit pfh_chk chk_u (.clk_i, .rst_i, .vector_bus_err_i, .data_bus_err_i,
  .misaligned_i, .zero_divide_i, .usage_en_i, .nmi_i, .cur_exc_i, .access_addr_i, .usage_clr_i,
  .fault_take_o, .fault_exc_o, .lockup_o, .hard_fault_cause_o, .bus_fault_cause_o,
  .usage_fault_cause_o, .bus_fault_location_o);

// *** verif/pfh_fault_unit_bench.sv ***
// self-checking bench for the fault unit
// assumes fixed one-cycle answer, so no handshake waits are needed
`timescale 1ns/100ps
`include "pfh_defs.vh"
module pfh_fault_unit_bench;
  reg clk_i, rst_i, nmi_i, mem_en_i, bus_en_i, usage_en_i, return_load_i;
  reg fetch_bus_err_i, vector_bus_err_i, data_bus_err_i, deferred_bus_err_i;
  reg push_bus_err_i, pop_bus_err_i, mpu_instr_viol_i, no_exec_fetch_i, mpu_data_viol_i;
  reg mpu_push_viol_i, mpu_pop_viol_i, coproc_access_i, unknown_opcode_i, foreign_iset_i;
  reg bad_resume_i, branch_state_change_i, misaligned_i, zero_divide_i;
  reg [31:0] return_code_i, access_addr_i;
  reg [3:0] cur_exc_i;
  reg [`PFH_PRI_W-1:0] cur_pri_i, mem_pri_i, bus_pri_i, usage_pri_i;
  reg [`PFH_HF_W-1:0] hard_clr_i;
  reg [`PFH_MF_W-1:0] mem_clr_i;
  reg [`PFH_BF_W-1:0] bus_clr_i;
  reg [`PFH_UF_W-1:0] usage_clr_i;
  wire fault_take_o, lockup_o;
  wire [3:0] fault_exc_o;
  wire [`PFH_HF_W-1:0] hard_fault_cause_o;
  wire [`PFH_MF_W-1:0] memory_fault_cause_o;
  wire [`PFH_BF_W-1:0] bus_fault_cause_o;
  wire [`PFH_UF_W-1:0] usage_fault_cause_o;
  wire [31:0] memory_fault_location_o, bus_fault_location_o;
  integer failures, checks, i;
  pfh_fault_unit dut_u (.clk_i, .rst_i, .fetch_bus_err_i, .vector_bus_err_i, .data_bus_err_i,
    .deferred_bus_err_i, .push_bus_err_i, .pop_bus_err_i, .mpu_instr_viol_i, .no_exec_fetch_i,
    .mpu_data_viol_i, .mpu_push_viol_i, .mpu_pop_viol_i, .coproc_access_i, .unknown_opcode_i,
    .foreign_iset_i, .bad_resume_i, .branch_state_change_i, .misaligned_i, .zero_divide_i,
    .return_load_i, .return_code_i, .access_addr_i, .cur_exc_i, .cur_pri_i, .mem_pri_i,
    .bus_pri_i, .usage_pri_i, .mem_en_i, .bus_en_i, .usage_en_i, .nmi_i, .hard_clr_i,
    .mem_clr_i, .bus_clr_i, .usage_clr_i, .fault_take_o, .fault_exc_o, .lockup_o,
    .hard_fault_cause_o, .memory_fault_cause_o, .bus_fault_cause_o, .usage_fault_cause_o,
    .memory_fault_location_o, .bus_fault_location_o);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task final_report;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task step;
    begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // one bit per event input; the full set is always driven so none is left stale
  task fire(input [18:0] m);
    begin
      {return_load_i, zero_divide_i, misaligned_i, branch_state_change_i, bad_resume_i,
        foreign_iset_i, unknown_opcode_i, coproc_access_i, mpu_pop_viol_i, mpu_push_viol_i,
        mpu_data_viol_i, no_exec_fetch_i, mpu_instr_viol_i, pop_bus_err_i, push_bus_err_i,
        deferred_bus_err_i, data_bus_err_i, vector_bus_err_i, fetch_bus_err_i} = m;
      step;
      {return_load_i, zero_divide_i, misaligned_i, branch_state_change_i, bad_resume_i,
        foreign_iset_i, unknown_opcode_i, coproc_access_i, mpu_pop_viol_i, mpu_push_viol_i,
        mpu_data_viol_i, no_exec_fetch_i, mpu_instr_viol_i, pop_bus_err_i, push_bus_err_i,
        deferred_bus_err_i, data_bus_err_i, vector_bus_err_i, fetch_bus_err_i} = 19'h00000;
    end
  endtask
  // exc of zero means no dispatch expected
  task look(input [3:0] exc, input [1:0] hf, input [3:0] mf, input [4:0] bf, input [5:0] uf);
    begin
      chk(fault_take_o, exc != 4'h0);
      if (exc != 4'h0) chk(fault_exc_o, exc);
      chk({hard_fault_cause_o, memory_fault_cause_o, bus_fault_cause_o, usage_fault_cause_o},
        {hf, mf, bf, uf});
      {hard_clr_i, mem_clr_i, bus_clr_i, usage_clr_i} = 17'h1FFFF;
      step;
      {hard_clr_i, mem_clr_i, bus_clr_i, usage_clr_i} = 17'h00000;
      chk(fault_take_o, 0);
      chk({hard_fault_cause_o, memory_fault_cause_o, bus_fault_cause_o, usage_fault_cause_o}, 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_bus;
    begin
      access_addr_i = 32'hA5A50004;
      fire(19'h00004);
      chk(bus_fault_location_o, 32'hA5A50004);
      look(4'h5, 2'h0, 4'h0, 5'h02, 6'h00);
      fire(19'h00001);
      look(4'h5, 2'h0, 4'h0, 5'h01, 6'h00);
      fire(19'h00008);
      look(4'h5, 2'h0, 4'h0, 5'h04, 6'h00);
      fire(19'h00010);
      look(4'h5, 2'h0, 4'h0, 5'h10, 6'h00);
      fire(19'h00020);
      look(4'h5, 2'h0, 4'h0, 5'h08, 6'h00);
      fire(19'h00002);
      look(4'h3, 2'h2, 4'h0, 5'h00, 6'h00);
    end
  endtask
  task t_mem;
    begin
      access_addr_i = 32'h20000010;
      fire(19'h00100);
      chk(memory_fault_location_o, 32'h20000010);
      look(4'h4, 2'h0, 4'h2, 5'h00, 6'h00);
      fire(19'h00040);
      look(4'h4, 2'h0, 4'h1, 5'h00, 6'h00);
      fire(19'h00080);
      look(4'h4, 2'h0, 4'h1, 5'h00, 6'h00);
      fire(19'h00200);
      look(4'h4, 2'h0, 4'h8, 5'h00, 6'h00);
      fire(19'h00400);
      look(4'h4, 2'h0, 4'h4, 5'h00, 6'h00);
    end
  endtask
  task t_usage;
    begin
      for (i = 11; i < 18; i = i + 1) begin
        fire(19'h00001 << i);
        look(4'h6, 2'h0, 4'h0, 5'h00, i == 11 ? 6'h08 : i == 12 ? 6'h01 : i == 16 ? 6'h10 :
          i == 17 ? 6'h20 : 6'h02);
      end
      for (i = 0; i < 5; i = i + 1) begin
        return_code_i = i == 0 ? 32'hFFFFFFF1 : i == 1 ? 32'hFFFFFFF9 : i == 2 ? 32'hFFFFFFFD :
          i == 3 ? 32'hFFFFFFF5 : 32'h7FFFFFF1;
        fire(19'h40000);
        look(i < 3 ? 4'h0 : 4'h6, 2'h0, 4'h0, 5'h00, i < 3 ? 6'h00 : 6'h04);
      end
    end
  endtask
  task t_esc;
    begin
      usage_en_i = 1'b0;
      fire(19'h20000);
      look(4'h3, 2'h1, 4'h0, 5'h00, 6'h20);
      usage_en_i = 1'b1;
      cur_exc_i = 4'h6;
      cur_pri_i = 3'h7;
      fire(19'h10000);
      look(4'h3, 2'h1, 4'h0, 5'h00, 6'h10);
      cur_exc_i = 4'h4;
      cur_pri_i = 3'h2;
      bus_pri_i = 3'h2;
      fire(19'h00004);
      look(4'h3, 2'h1, 4'h0, 5'h02, 6'h00);
      bus_pri_i = 3'h1;
      fire(19'h00004);
      look(4'h5, 2'h0, 4'h0, 5'h02, 6'h00);
      cur_exc_i = 4'h5;
      fire(19'h00010);
      look(4'h5, 2'h0, 4'h0, 5'h10, 6'h00);
      cur_exc_i = 4'h0;
      {mem_pri_i, bus_pri_i} = 6'h1B;
      fire(19'h00104);
      look(4'h4, 2'h0, 4'h2, 5'h02, 6'h00);
    end
  endtask
  task t_lock;
    begin
      cur_exc_i = 4'h3;
      fire(19'h20000);
      chk({lockup_o, fault_take_o, usage_fault_cause_o[5]}, 3'h5);
      step;
      fire(19'h10000);
      chk(usage_fault_cause_o[4], 0);
      nmi_i = 1'b1;
      step;
      nmi_i = 1'b0;
      chk(lockup_o, 0);
      cur_exc_i = 4'h2;
      fire(19'h20000);
      nmi_i = 1'b1;
      step;
      nmi_i = 1'b0;
      chk(lockup_o, 1);
      rst_i = 1'b1;
      step;
      rst_i = 1'b0;
      chk({lockup_o, usage_fault_cause_o}, 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    checks = 0;
    rst_i = 1'b1;
    {nmi_i, cur_exc_i, cur_pri_i, mem_pri_i, bus_pri_i, usage_pri_i} = 17'h00000;
    {mem_en_i, bus_en_i, usage_en_i} = 3'h7;
    {return_code_i, access_addr_i} = 64'h0;
    {hard_clr_i, mem_clr_i, bus_clr_i, usage_clr_i} = 17'h00000;
    fire(19'h00000);
    step;
    rst_i = 1'b0;
    t_bus;
    t_mem;
    t_usage;
    t_esc;
    t_lock;
    final_report;
  end
  // the run is a fixed sequence; this only guards against a stalled clock
  initial begin
    #200000;
    failures = failures + 1;
    final_report;
  end
endmodule // pfh_fault_unit_bench
